/* core/difd_cfg.svh */
/*
 * Field positions, opcode codes, limits and cycle counts of the
 * instruction format decoder. Assumes a 24-bit program word.
 */
`ifndef DIFD_CFG_SVH
`define DIFD_CFG_SVH

`define DIFD_WORD_W       24
`define DIFD_OPC_W        8
`define DIFD_F_OPC        23:16
`define DIFD_F_CLS        23:21
`define DIFD_F_SUB        20:16
`define DIFD_F_SIZE       16
`define DIFD_F_ACC        16
`define DIFD_F_WBK_EN     17
`define DIFD_F_BASE       15:12
`define DIFD_F_DMODE      11:10
`define DIFD_F_DREG       9:6
`define DIFD_F_SMODE      5:4
`define DIFD_F_SREG       3:0
`define DIFD_F_FDEST      13
`define DIFD_F_FADDR      12:0
`define DIFD_F_BITFILE    11
`define DIFD_F_BFADDR     10:0
`define DIFD_F_ULIT       13:4
`define DIFD_F_LREG       3:0
`define DIFD_F_LIT5       11:7
`define DIFD_F_ADMODE     6:5
`define DIFD_F_ADREG      4:1
`define DIFD_F_SLIT       9:0
`define DIFD_F_SHADOW     15
`define DIFD_F_MULPAIR    15:13
`define DIFD_F_XPF        12:9
`define DIFD_F_XD         8:7
`define DIFD_F_YPF        6:3
`define DIFD_F_YD         2:1
`define DIFD_F_WBK_INC    0
`define DIFD_F_SHSEL      15
`define DIFD_F_SHREG      12:9
`define DIFD_F_SHLIT      14:9
`define DIFD_F_OMODE      7:6
`define DIFD_F_OREG       5:2
`define DIFD_F_PAL_W1     15:1
`define DIFD_F_PAL_W2     6:0
`define DIFD_SUB_NOP      5'h00
`define DIFD_SUB_BRANCH   5'h01
`define DIFD_SUB_BR_COMP  5'h02
`define DIFD_SUB_CALL_IND 5'h03
`define DIFD_SUB_GOTO_IND 5'h04
`define DIFD_SUB_TBL_RD   5'h05
`define DIFD_SUB_TBL_WR   5'h06
`define DIFD_SUB_RET      5'h07
`define DIFD_SUB_RETI     5'h08
`define DIFD_SUB_COND_BR  5'h09
`define DIFD_SUB_SKIP     5'h0A
`define DIFD_SUB_MOV_D    5'h0B
`define DIFD_SUB_GOTO     5'h0C
`define DIFD_SUB_CALL     5'h0D
`define DIFD_SUB_DO       5'h0E
`define DIFD_SUB_PUSH_S   5'h0F
`define DIFD_CYC_NONE     2'h0
`define DIFD_CYC_ONE      2'h1
`define DIFD_CYC_TWO      2'h2
`define DIFD_CYC_THREE    2'h3
`define DIFD_BYTE_LIT_MAX 10'h0FF
`define DIFD_FILE_MAX     13'h1FFF
`define DIFD_W0           4'h0
`define DIFD_W4           4'h4
`define DIFD_WBK_REG      4'hD
`define DIFD_PF_X_BASE    4'h8
`define DIFD_PF_Y_BASE    4'hA
`define DIFD_PF_PER_REG   4'h7
`define DIFD_PF_INDEXED   4'hE
`define DIFD_PF_NONE      4'hF
`define DIFD_PF_INDEX_REG 4'hC

`endif

/* core/difd_decoder.sv */
/*
 * Instruction format decoder: classifies each fetched 24-bit word,
 * splits its operand fields, pairs two-word instructions, predicts the
 * instruction-cycle count and holds the core and DSP status flags.
 * Assumes fetch_word/next_word come from same-clock fetch logic.
 */
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/10ps
`include "difd_cfg.svh"

module difd_decoder
  import difd_pkg::*;
#(
  parameter int WORD_W = `DIFD_WORD_W,
  parameter int OPC_W  = `DIFD_OPC_W
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              word_valid,
  input  wire logic [WORD_W-1:0] fetch_word,
  input  wire logic [WORD_W-1:0] next_word,
  input  wire logic              cond_true,
  input  wire logic              pc_write_hit,
  input  wire logic              core_flags_we,
  input  wire logic [4:0]        core_flags_in,
  input  wire logic              dsp_flags_we,
  input  wire logic [3:0]        dsp_flags_in,
  output logic                   dec_valid,
  output difd_class_type         instr_class,
  output difd_size_type          operand_size,
  output logic                   shadow_select,
  output logic                   second_word_follows,
  output logic                   second_word_seen,
  output logic [1:0]             cycle_count,
  output logic [3:0]             base_operand_reg,
  output logic [3:0]             source_operand_reg,
  output logic [1:0]             source_mode,
  output logic [3:0]             dest_operand_reg,
  output logic [1:0]             dest_mode,
  output logic                   dest_used,
  output logic [12:0]            file_addr,
  output logic                   file_op_default_target,
  output logic [3:0]             bit_position_field,
  output logic                   bit_pos_from_reg,
  output logic                   bit_target_is_file,
  output logic [9:0]             ten_bit_unsigned_literal,
  output logic [4:0]             small_literal,
  output logic [15:0]            ten_bit_signed_literal,
  output logic [22:0]            program_address_literal,
  output logic                   accum_select,
  output logic [3:0]             mul_reg_a,
  output logic [3:0]             mul_reg_b,
  output logic [3:0]             pf_addr_reg [2],
  output logic signed [3:0]      pf_post_mod [2],
  output logic                   pf_indexed [2],
  output logic                   pf_enable [2],
  output logic [3:0]             pf_dest_reg [2],
  output logic                   wbk_enable,
  output logic [3:0]             accum_writeback_dest,
  output logic                   wbk_post_inc,
  output logic                   shift_from_reg,
  output logic [3:0]             shift_amount_reg,
  output logic [5:0]             shift_literal,
  output logic                   literal_range_err,
  output logic                   second_word_err,
  output logic                   carry_flag,
  output logic                   digit_carry_flag,
  output logic                   negative_flag,
  output logic                   overflow_flag,
  output logic                   zero_flag,
  output logic                   accum_a_overflow_flag,
  output logic                   accum_b_overflow_flag,
  output logic                   accum_a_saturate_flag,
  output logic                   accum_b_saturate_flag
);

  if (WORD_W != `DIFD_WORD_W || OPC_W != `DIFD_OPC_W) begin : g_bad_width
    $error("difd_decoder serves only a 24-bit word with an 8-bit opcode");
  end

  difd_state_type st_r;
  logic [WORD_W-1:0] first_word_r;
  difd_class_type cls;
  logic [4:0] sub;
  logic [1:0] cyc_nxt;
  difd_size_type size_nxt;
  logic [3:0] mul_a_nxt;
  logic [3:0] mul_b_nxt;
  logic take_first;
  logic take_second;
  logic [3:0] pf_reg_nxt [2];
  logic signed [3:0] pf_mod_nxt [2];
  logic pf_idx_nxt [2];
  logic pf_en_nxt [2];
  logic [3:0] pf_dst_nxt [2];

  function automatic logic two_word(input logic [WORD_W-1:0] w);
    logic [4:0] s;
    s = w[`DIFD_F_SUB];
    two_word = (w[`DIFD_F_CLS] == CLS_CTRL) && (s == `DIFD_SUB_GOTO ||
               s == `DIFD_SUB_CALL || s == `DIFD_SUB_DO);
  endfunction

  function automatic logic signed [3:0] pf_mod(input logic [3:0] k);
    case (k)
      4'h0:    pf_mod = 4'sh6;
      4'h1:    pf_mod = 4'sh4;
      4'h2:    pf_mod = 4'sh2;
      4'h4:    pf_mod = -4'sh6;
      4'h5:    pf_mod = -4'sh4;
      4'h6:    pf_mod = -4'sh2;
      default: pf_mod = 4'sh0;
    endcase
  endfunction

  assign cls         = difd_class_type'(fetch_word[`DIFD_F_CLS]);
  assign sub         = fetch_word[`DIFD_F_SUB];
  assign take_first  = word_valid && (st_r == ST_FIRST);
  assign take_second = word_valid && (st_r == ST_SECOND);

  // sequencing of two-word instructions
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_r         <= ST_FIRST;
      first_word_r <= '0;
    end else begin
      case (st_r)
        ST_FIRST: begin
          if (word_valid && two_word(fetch_word)) begin
            st_r         <= ST_SECOND;
            first_word_r <= fetch_word;
          end
        end
        ST_SECOND: begin
          if (word_valid) begin
            st_r <= ST_FIRST;
          end
        end
        default: st_r <= ST_FIRST;
      endcase
    end
  end

  // cycle count prediction
  always_comb begin
    cyc_nxt = pc_write_hit ? `DIFD_CYC_TWO : `DIFD_CYC_ONE;
    if (cls == CLS_CTRL) begin
      case (sub)
        `DIFD_SUB_BRANCH, `DIFD_SUB_BR_COMP, `DIFD_SUB_CALL_IND,
        `DIFD_SUB_GOTO_IND, `DIFD_SUB_TBL_RD, `DIFD_SUB_TBL_WR: begin
          cyc_nxt = `DIFD_CYC_TWO;
        end
        `DIFD_SUB_RET, `DIFD_SUB_RETI: begin
          cyc_nxt = `DIFD_CYC_THREE;
        end
        `DIFD_SUB_COND_BR: begin
          cyc_nxt = cond_true ? `DIFD_CYC_TWO : `DIFD_CYC_ONE;
        end
        `DIFD_SUB_SKIP: begin
          if (!cond_true) begin
            cyc_nxt = `DIFD_CYC_ONE;
          end else if (two_word(next_word)) begin
            cyc_nxt = `DIFD_CYC_THREE;
          end else begin
            cyc_nxt = `DIFD_CYC_TWO;
          end
        end
        `DIFD_SUB_MOV_D: begin
          cyc_nxt = `DIFD_CYC_TWO;
        end
        `DIFD_SUB_GOTO, `DIFD_SUB_CALL, `DIFD_SUB_DO: begin
          cyc_nxt = `DIFD_CYC_TWO;
        end
        `DIFD_SUB_NOP: begin
          cyc_nxt = `DIFD_CYC_ONE;
        end
        default: ;
      endcase
    end
  end

  // operand size and multiplicand pair
  always_comb begin
    size_nxt = SIZE_WORD;
    if ((cls == CLS_WORD_W || cls == CLS_WORD_F || cls == CLS_LIT_MOV ||
         cls == CLS_LIT_ARITH) && fetch_word[`DIFD_F_SIZE]) begin
      size_nxt = SIZE_BYTE;
    end else if (cls == CLS_CTRL && sub == `DIFD_SUB_MOV_D) begin
      size_nxt = SIZE_DWORD;
    end
    case (fetch_word[`DIFD_F_MULPAIR])
      3'h0:    {mul_a_nxt, mul_b_nxt} = {4'h4, 4'h5};
      3'h1:    {mul_a_nxt, mul_b_nxt} = {4'h4, 4'h6};
      3'h2:    {mul_a_nxt, mul_b_nxt} = {4'h4, 4'h7};
      3'h3:    {mul_a_nxt, mul_b_nxt} = {4'h5, 4'h6};
      3'h4:    {mul_a_nxt, mul_b_nxt} = {4'h5, 4'h7};
      3'h5:    {mul_a_nxt, mul_b_nxt} = {4'h6, 4'h7};
      default: {mul_a_nxt, mul_b_nxt} = {4'h0, 4'h0};
    endcase
  end

  // X and Y prefetch decode
  for (genvar gi = 0; gi < 2; gi++) begin : g_pf
    logic [3:0] code;
    logic [3:0] base;
    logic       upper;
    assign code  = (gi == 0) ? fetch_word[`DIFD_F_XPF] : fetch_word[`DIFD_F_YPF];
    assign base  = (gi == 0) ? `DIFD_PF_X_BASE : `DIFD_PF_Y_BASE;
    assign upper = code >= `DIFD_PF_PER_REG;
    assign pf_idx_nxt[gi] = code == `DIFD_PF_INDEXED;
    assign pf_en_nxt[gi]  = code != `DIFD_PF_NONE;
    assign pf_reg_nxt[gi] = base + {3'h0, upper || pf_idx_nxt[gi]};
    assign pf_mod_nxt[gi] = pf_mod(upper ? code - `DIFD_PF_PER_REG : code);
    assign pf_dst_nxt[gi] = `DIFD_W4 + {2'h0, (gi == 0) ?
                            fetch_word[`DIFD_F_XD] : fetch_word[`DIFD_F_YD]};
  end

  // decoded fields, one set per instruction
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dec_valid                <= 1'b0;
      instr_class              <= CLS_CTRL;
      operand_size             <= SIZE_WORD;
      shadow_select            <= 1'b0;
      second_word_follows      <= 1'b0;
      second_word_seen         <= 1'b0;
      cycle_count              <= `DIFD_CYC_NONE;
      base_operand_reg         <= '0;
      source_operand_reg       <= '0;
      source_mode              <= '0;
      dest_operand_reg         <= '0;
      dest_mode                <= '0;
      dest_used                <= 1'b0;
      file_addr                <= '0;
      file_op_default_target   <= 1'b0;
      bit_position_field       <= '0;
      bit_pos_from_reg         <= 1'b0;
      bit_target_is_file       <= 1'b0;
      ten_bit_unsigned_literal <= '0;
      small_literal            <= '0;
      ten_bit_signed_literal   <= '0;
      program_address_literal  <= '0;
      accum_select             <= 1'b0;
      mul_reg_a                <= '0;
      mul_reg_b                <= '0;
      pf_addr_reg              <= '{default: '0};
      pf_post_mod              <= '{default: '0};
      pf_indexed               <= '{default: 1'b0};
      pf_enable                <= '{default: 1'b0};
      pf_dest_reg              <= '{default: '0};
      wbk_enable               <= 1'b0;
      accum_writeback_dest     <= '0;
      wbk_post_inc             <= 1'b0;
      shift_from_reg           <= 1'b0;
      shift_amount_reg         <= '0;
      shift_literal            <= '0;
      literal_range_err        <= 1'b0;
      second_word_err          <= 1'b0;
    end else if (take_second) begin
      dec_valid               <= 1'b1;
      second_word_seen        <= 1'b1;
      second_word_follows     <= 1'b0;
      cycle_count             <= `DIFD_CYC_NONE;
      program_address_literal <= {fetch_word[`DIFD_F_PAL_W2],
                                  first_word_r[`DIFD_F_PAL_W1], 1'b0};
      second_word_err         <= fetch_word[`DIFD_F_OPC] != 8'h00;
    end else if (take_first) begin
      dec_valid                <= 1'b1;
      instr_class              <= cls;
      operand_size             <= size_nxt;
      shadow_select            <= cls == CLS_CTRL && sub == `DIFD_SUB_PUSH_S &&
                                  fetch_word[`DIFD_F_SHADOW];
      second_word_follows      <= two_word(fetch_word);
      second_word_seen         <= 1'b0;
      cycle_count              <= cyc_nxt;
      base_operand_reg         <= fetch_word[`DIFD_F_BASE];
      source_operand_reg       <= (cls == CLS_DSP_OTHER) ? fetch_word[`DIFD_F_OREG] :
                                  fetch_word[`DIFD_F_SREG];
      source_mode              <= (cls == CLS_DSP_OTHER) ? fetch_word[`DIFD_F_OMODE] :
                                  fetch_word[`DIFD_F_SMODE];
      dest_operand_reg         <= (cls == CLS_LIT_ARITH) ? fetch_word[`DIFD_F_ADREG] :
                                  (cls == CLS_LIT_MOV) ? fetch_word[`DIFD_F_LREG] :
                                  fetch_word[`DIFD_F_DREG];
      dest_mode                <= (cls == CLS_LIT_ARITH) ? fetch_word[`DIFD_F_ADMODE] :
                                  fetch_word[`DIFD_F_DMODE];
      dest_used                <= (cls == CLS_LIT_ARITH) ?
                                  fetch_word[`DIFD_F_ADREG] != fetch_word[`DIFD_F_BASE] :
                                  1'b1;
      file_addr                <= (cls == CLS_BIT) ? {2'h0, fetch_word[`DIFD_F_BFADDR]} :
                                  fetch_word[`DIFD_F_FADDR] & `DIFD_FILE_MAX;
      file_op_default_target   <= cls == CLS_WORD_F && fetch_word[`DIFD_F_FDEST];
      bit_position_field       <= fetch_word[`DIFD_F_BASE];
      bit_pos_from_reg         <= cls == CLS_BIT && fetch_word[`DIFD_F_SIZE];
      bit_target_is_file       <= cls == CLS_BIT && fetch_word[`DIFD_F_BITFILE];
      ten_bit_unsigned_literal <= fetch_word[`DIFD_F_ULIT];
      small_literal            <= fetch_word[`DIFD_F_LIT5];
      ten_bit_signed_literal   <= {{6{fetch_word[9]}}, fetch_word[`DIFD_F_SLIT]};
      accum_select             <= fetch_word[`DIFD_F_ACC];
      mul_reg_a                <= mul_a_nxt;
      mul_reg_b                <= mul_b_nxt;
      for (int i = 0; i < 2; i++) begin
        pf_addr_reg[i] <= pf_reg_nxt[i];
        pf_post_mod[i] <= pf_mod_nxt[i];
        pf_indexed[i]  <= pf_idx_nxt[i];
        pf_enable[i]   <= pf_en_nxt[i] && cls == CLS_DSP_MAC;
        pf_dest_reg[i] <= pf_dst_nxt[i];
      end
      wbk_enable               <= cls == CLS_DSP_MAC && fetch_word[`DIFD_F_WBK_EN];
      accum_writeback_dest     <= `DIFD_WBK_REG;
      wbk_post_inc             <= fetch_word[`DIFD_F_WBK_INC];
      shift_from_reg           <= fetch_word[`DIFD_F_SHSEL];
      shift_amount_reg         <= fetch_word[`DIFD_F_SHREG];
      shift_literal            <= fetch_word[`DIFD_F_SHLIT];
      literal_range_err        <= cls == CLS_LIT_MOV && fetch_word[`DIFD_F_SIZE] &&
                                  fetch_word[`DIFD_F_ULIT] > `DIFD_BYTE_LIT_MAX;
      second_word_err          <= 1'b0;
    end else begin
      dec_valid <= 1'b0;
    end
  end

  // status flag storage
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      {carry_flag, digit_carry_flag, negative_flag, overflow_flag, zero_flag} <= 5'h00;
      {accum_a_overflow_flag, accum_b_overflow_flag,
       accum_a_saturate_flag, accum_b_saturate_flag} <= 4'h0;
    end else begin
      if (core_flags_we) begin
        {carry_flag, digit_carry_flag, negative_flag, overflow_flag,
         zero_flag} <= core_flags_in;
      end
      if (dsp_flags_we) begin
        {accum_a_overflow_flag, accum_b_overflow_flag,
         accum_a_saturate_flag, accum_b_saturate_flag} <= dsp_flags_in;
      end
    end
  end

endmodule

/* core/difd_pkg.sv */
/*
 * Types of the instruction format decoder: classes, sizes, states.
 * Assumes the constants of difd_cfg.svh.
 */
package difd_pkg;
  typedef enum logic [2:0] {
    CLS_CTRL      = 3'h0,
    CLS_LIT_MOV   = 3'h1,
    CLS_WORD_W    = 3'h2,
    CLS_WORD_F    = 3'h3,
    CLS_LIT_ARITH = 3'h4,
    CLS_BIT       = 3'h5,
    CLS_DSP_MAC   = 3'h6,
    CLS_DSP_OTHER = 3'h7
  } difd_class_type;

  typedef enum logic [1:0] {
    SIZE_WORD  = 2'h0,
    SIZE_BYTE  = 2'h1,
    SIZE_DWORD = 2'h2
  } difd_size_type;

  typedef enum logic [1:0] {
    ST_FIRST  = 2'h1,
    ST_SECOND = 2'h2
  } difd_state_type;
endpackage

/* sim/difd_decoder_props.sv */
/*
 * Concurrent checks on the format decoder ports.
 * Assumes binding into difd_decoder, one clock, rst async high.
 */
`timescale 1ns/10ps
module difd_decoder_props
  import difd_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        word_valid,
  input wire logic [23:0] fetch_word,
  input wire logic        core_flags_we,
  input wire logic [4:0]  core_flags_in,
  input wire logic        dec_valid,
  input difd_class_type   instr_class,
  input wire logic        second_word_follows,
  input wire logic        second_word_seen,
  input wire logic [1:0]  cycle_count,
  input wire logic [22:0] program_address_literal,
  input wire logic        second_word_err,
  input wire logic        wbk_enable,
  input wire logic [3:0]  accum_writeback_dest,
  input wire logic [15:0] ten_bit_signed_literal,
  input wire logic        carry_flag,
  input wire logic        digit_carry_flag,
  input wire logic        negative_flag,
  input wire logic        overflow_flag,
  input wire logic        zero_flag
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_answer; word_valid |=> dec_valid; endproperty
  property p_pair; dec_valid && second_word_follows |-> cycle_count == 2'h2; endproperty
  property p_lone; dec_valid && second_word_seen |-> cycle_count == 2'h0 && !second_word_follows;
  endproperty
  property p_err;
    dec_valid && second_word_follows && word_valid |=> second_word_seen &&
      (second_word_err == (($past(fetch_word) & 24'hFF_0000) != 24'h00_0000));
  endproperty
  property p_lsb; dec_valid |-> !program_address_literal[0]; endproperty
  property p_wbk; dec_valid && instr_class == CLS_DSP_MAC && wbk_enable |->
    accum_writeback_dest == 4'hD; endproperty
  property p_sign; dec_valid |-> ten_bit_signed_literal[15:10] == {6{ten_bit_signed_literal[9]}};
  endproperty
  property p_flags; core_flags_we |=> {carry_flag, digit_carry_flag, negative_flag,
    overflow_flag, zero_flag} == $past(core_flags_in); endproperty
  property p_three; dec_valid && cycle_count == 2'h3 |-> instr_class == CLS_CTRL; endproperty
  a_answer: assert property (p_answer) else $error("no decode after take");
  a_pair: assert property (p_pair) else $error("two-word count wrong");
  a_lone: assert property (p_lone) else $error("second word not idle");
  a_err: assert property (p_err) else $error("second word flag wrong");
  a_lsb: assert property (p_lsb) else $error("address literal odd");
  a_wbk: assert property (p_wbk) else $error("write-back not reg 13");
  a_sign: assert property (p_sign) else $error("signed literal not extended");
  a_flags: assert property (p_flags) else $error("core flags not stored");
  a_three: assert property (p_three) else $error("three cycles off control");
  c_pair: cover property (dec_valid && second_word_seen);
  c_three: cover property (dec_valid && cycle_count == 2'h3);
  c_wbk: cover property (dec_valid && wbk_enable);
endmodule

bind difd_decoder difd_decoder_props difd_decoder_props_inst (.*);

/* sim/difd_fetch_model.sv */
/*
 * Program memory fetch path model, one word per take.
 * Assumes the caller calls put or rel right after a rising edge.
 */
`timescale 1ns/10ps
module difd_fetch_model (
  output logic        word_valid,
  output logic [23:0] fetch_word,
  output logic [23:0] next_word
);
  initial begin
    word_valid = 1'b0;
    fetch_word = 24'h00_0000;
    next_word = 24'h00_0000;
  end
  task automatic put(input logic [23:0] w, input logic [23:0] nw);
    word_valid <= 1'b1;
    fetch_word <= w;
    next_word <= nw;
  endtask
  // released bus shows no stale word
  task automatic rel();
    word_valid <= 1'b0;
    fetch_word <= ~fetch_word;
    next_word <= ~next_word;
  endtask
endmodule

/* sim/testbench.sv */
/*
 * Self-checking bench of the format decoder against a queue model.
 * Assumes difd_cfg.svh encodings and a 200 MHz core_clk.
 */
`timescale 1ns/10ps
module testbench
  import difd_pkg::*;
;
  typedef struct {int cls; int sz; int cyc; int fol; int seen; int pal; int err;} difd_exp_type;
  logic core_clk, rst, word_valid, cond_true, pc_write_hit, core_flags_we, dsp_flags_we;
  logic [23:0] fetch_word, next_word, w1;
  logic [4:0] core_flags_in, small_literal, ef;
  logic [3:0] dsp_flags_in, ed, base_operand_reg, source_operand_reg, dest_operand_reg;
  logic [3:0] bit_position_field, mul_reg_a, mul_reg_b, accum_writeback_dest, shift_amount_reg;
  logic [3:0] pf_addr_reg [2], pf_dest_reg [2];
  logic signed [3:0] pf_post_mod [2];
  logic pf_indexed [2], pf_enable [2];
  logic [1:0] source_mode, dest_mode, cycle_count;
  logic [12:0] file_addr;
  logic [9:0] ten_bit_unsigned_literal;
  logic [15:0] ten_bit_signed_literal;
  logic [22:0] program_address_literal;
  logic [5:0] shift_literal;
  difd_class_type instr_class;
  difd_size_type operand_size;
  logic dec_valid, shadow_select, second_word_follows, second_word_seen, dest_used;
  logic file_op_default_target, bit_pos_from_reg, bit_target_is_file, accum_select;
  logic wbk_enable, wbk_post_inc, shift_from_reg, literal_range_err, second_word_err;
  logic carry_flag, digit_carry_flag, negative_flag, overflow_flag, zero_flag;
  logic accum_a_overflow_flag, accum_b_overflow_flag, accum_a_saturate_flag;
  logic accum_b_saturate_flag, took, pend;
  logic [31:0] seed, r, r2;
  int n_mismatch, num_checks, n_cyc;
  difd_exp_type q[$], e;
  wire [4:0] corf = {carry_flag, digit_carry_flag, negative_flag, overflow_flag, zero_flag};
  wire [3:0] dspf = {accum_a_overflow_flag, accum_b_overflow_flag,
                     accum_a_saturate_flag, accum_b_saturate_flag};

  difd_fetch_model difd_fetch_model_inst (.*);
  difd_decoder difd_decoder_inst (.*);

  initial core_clk = 1'b0;
  always #2.5 core_clk = ~core_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic tdone(input string n);
    $display("test %s done, %0d checks so far", n, num_checks);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic tw(input logic [23:0] x);
    return x[23:21] == 3'h0 && x[20:16] inside {5'h0C, 5'h0D, 5'h0E};
  endfunction
  function automatic difd_exp_type model(input logic [23:0] w, nw, input logic c, p);
    difd_exp_type m;
    m = '{-1, -1, 0, 0, 1, -1, -1};
    if (pend) begin
      m.pal = {w[6:0], w1[15:1], 1'b0};
      m.err = w[23:16] != 8'h00;
      pend = 1'b0;
      return m;
    end
    m.seen = 0;
    m.cls = w[23:21];
    m.sz = (w[23:21] inside {[3'h1:3'h4]} && w[16]) ? 1 : 0;
    m.cyc = p ? 2 : 1;
    if (w[23:21] == 3'h0) begin
      m.sz = (w[20:16] == 5'h0B) ? 2 : 0;
      case (w[20:16])
        5'h00: m.cyc = 1;
        5'h07, 5'h08: m.cyc = 3;
        5'h09: m.cyc = c ? 2 : 1;
        5'h0A: m.cyc = c ? (tw(nw) ? 3 : 2) : 1;
        default: if (w[20:16] < 5'h0F) m.cyc = 2;
      endcase
    end
    m.fol = tw(w);
    pend = tw(w);
    w1 = w;
    return m;
  endfunction
  task automatic send(input logic [23:0] w, nw, input logic c, p);
    @(posedge core_clk);
    difd_fetch_model_inst.put(w, nw);
    cond_true <= c;
    pc_write_hit <= p;
    q.push_back(model(w, nw, c, p));
  endtask
  task automatic rel();
    @(posedge core_clk);
    difd_fetch_model_inst.rel();
    cond_true <= 1'b0;
    pc_write_hit <= 1'b0;
  endtask
  task automatic one(input logic [23:0] w);
    send(w, 24'h00_0000, 1'b0, 1'b0);
    rel();
    @(negedge core_clk);
  endtask

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      took <= 1'b0;
      ef <= 5'h00;
      ed <= 4'h0;
    end else begin
      took <= word_valid;
      if (core_flags_we) ef <= core_flags_in;
      if (dsp_flags_we) ed <= dsp_flags_in;
    end
  end
  always @(negedge core_clk) begin
    if (!rst) begin
      chk(dec_valid, took);
      chk(corf, ef);
      chk(dspf, ed);
      if (took && q.size() > 0) begin
        e = q.pop_front();
        if (e.cls >= 0) chk(instr_class, e.cls);
        if (e.sz >= 0) chk(operand_size, e.sz);
        chk(cycle_count, e.cyc);
        chk(second_word_follows, e.fol);
        chk(second_word_seen, e.seen);
        if (e.pal >= 0) chk(program_address_literal, e.pal);
        if (e.err >= 0) chk(second_word_err, e.err);
      end
    end
  end
  always @(posedge core_clk) begin
    n_cyc++;
    if (n_cyc == 6000) begin
      n_mismatch++;
      complete_run();
    end
  end

  initial begin
    rst = 1'b1;
    cond_true = 1'b0;
    pc_write_hit = 1'b0;
    core_flags_we = 1'b0;
    core_flags_in = 5'h00;
    dsp_flags_we = 1'b0;
    dsp_flags_in = 4'h0;
    pend = 1'b0;
    seed = 32'h0000_0025;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      for (int s = 0; s < 16; s++) begin
        send({3'h0, s[4:0], 16'h1234}, k == 2 ? 24'h0D_0000 : 24'h00_0000, k > 0, 1'b0);
      end
      rel();
    end
    tdone("control codes");
    send(24'h0D_ABCD, 24'h00_0000, 1'b0, 1'b0);
    send(24'h5A_1235, 24'h00_0000, 1'b0, 1'b0);
    send(24'h0C_FFFE, 24'h00_0000, 1'b0, 1'b0);
    send(24'h00_007F, 24'h00_0000, 1'b0, 1'b0);
    send(24'h00_007F, 24'h00_0000, 1'b1, 1'b1);
    rel();
    tdone("two-word");
    one({3'h2, 4'h0, 1'b1, 4'hA, 2'h2, 4'h5, 2'h3, 4'h7});
    chk({base_operand_reg, dest_mode, dest_operand_reg}, 10'h2A5);
    chk({source_mode, source_operand_reg}, 6'h37);
    one({3'h3, 5'h00, 2'h0, 1'b1, 13'h1FFF});
    chk({file_op_default_target, file_addr}, 14'h3FFF);
    one({3'h5, 4'h0, 1'b0, 4'hF, 1'b1, 11'h7FF});
    chk({bit_position_field, bit_pos_from_reg, bit_target_is_file}, 6'h3D);
    one({3'h1, 4'h0, 1'b1, 2'h0, 10'h100, 4'h3});
    chk({literal_range_err, ten_bit_unsigned_literal}, 11'h500);
    one({3'h1, 4'h0, 1'b0, 2'h0, 10'h3FF, 4'h3});
    chk({literal_range_err, ten_bit_unsigned_literal}, 11'h3FF);
    one({3'h4, 4'h0, 1'b0, 4'h6, 5'h1F, 2'h0, 4'h6, 1'b0});
    chk({dest_used, small_literal}, 6'h1F);
    one({3'h6, 3'h0, 1'b1, 1'b1, 3'h5, 4'hE, 2'h2, 4'h4, 2'h3, 1'b1});
    chk({accum_select, mul_reg_a, mul_reg_b}, 9'h167);
    chk({pf_addr_reg[0], pf_indexed[0], pf_dest_reg[0], pf_enable[0]}, 10'h26D);
    chk({pf_addr_reg[1], pf_post_mod[1], pf_dest_reg[1], pf_indexed[1]}, 13'h154E);
    chk({wbk_enable, accum_writeback_dest, wbk_post_inc}, 6'h3B);
    one({3'h7, 4'h0, 1'b1, 1'b1, 2'h0, 4'hB, 1'b0, 2'h1, 4'h9, 2'h0});
    chk({accum_select, shift_from_reg, shift_amount_reg, shift_literal}, 12'hECB);
    chk({source_mode, source_operand_reg, ten_bit_signed_literal}, 22'h19_FE64);
    one(24'h0F_8000);
    chk(shadow_select, 1'b1);
    tdone("operand fields");
    for (int i = 0; i < 300; i++) begin
      r = xs();
      r2 = xs();
      send(r[23:0], r2[23:0], r[24], r[25]);
      core_flags_we <= r[26];
      core_flags_in <= r[31:27];
      dsp_flags_we <= r[28];
      dsp_flags_in <= r2[27:24];
      if (r[29]) rel();
    end
    rel();
    core_flags_we <= 1'b0;
    dsp_flags_we <= 1'b0;
    tdone("random");
    @(posedge core_clk);
    rst <= 1'b1;
    pend = 1'b0;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    chk({dec_valid, cycle_count, second_word_follows, corf, dspf}, 13'h0000);
    one(24'h00_0000);
    tdone("reset");
    complete_run();
  end
endmodule
